// >>> hw/crh_regs.sv
`timescale 1ns/100ps
// command, link-owner and buffer control register bank
module crh_regs
   import crh_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire crh_req_t req,
   input wire logic cmd_done,
   input wire logic [9:0] fill_count,
   output logic [7:0] rdata,
   output logic power_down,
   output logic radio_power_down,
   output logic [4:0] command_code,
   output crh_owner_t owner,
   output logic owner_write_unlock,
   output logic buffer_depth_select,
   output logic buffer_clear,
   output logic [8:0] threshold,
   output logic near_full_flag,
   output logic near_empty_flag
);
   logic [7:0] cmd_q, cmd_d;
   logic unlock_q, unlock_d;
   crh_owner_t own_q, own_d;
   logic depth_q, depth_d;
   logic [8:0] thr_q, thr_d;
   logic clear_q, clear_d;
   logic [7:0] rdata_q, rdata_d;
   logic full_q, empty_q;
   logic full_c, empty_c;
   logic [9:0] size_c, thr_c, fill_c;
   logic wr_cmd, wr_own, wr_buf, wr_thr;

   assign wr_cmd = req.wr && (req.addr == CRH_OFS_COMMAND);
   assign wr_own = req.wr && (req.addr == CRH_OFS_OWNER);
   assign wr_buf = req.wr && (req.addr == CRH_OFS_BUFFER);
   assign wr_thr = req.wr && (req.addr == CRH_OFS_THRESHOLD);

   // in 255-byte mode the extension bits are not evaluated
   always_comb
   begin
      size_c = depth_q ? CRH_DEPTH_SMALL : CRH_DEPTH_LARGE; // RULE13
      thr_c = depth_q ? {2'h0, thr_q[7:0]} : {1'b0, thr_q};
      fill_c = depth_q ? {2'h0, fill_count[7:0]} : fill_count;
   end

   crh_level_cmp #(.W(10)) u_cmp (
      .size(size_c),
      .fill(fill_c),
      .thr(thr_c),
      .near_full(full_c),
      .near_empty(empty_c)
   );

   // command register: host write, command clears itself when done
   always_comb
   begin
      cmd_d = cmd_q;
      if (cmd_done)
         cmd_d[4:0] = CRH_CMD_IDLE; // RULE4
      if (wr_cmd)
      begin
         cmd_d = {req.wdata[7:6], 1'b0, req.wdata[4:0]}; // RULE1 RULE2 RULE3 RULE4
      end
   end

   // owner register: one write per unlock, owners never both set
   always_comb
   begin
      unlock_d = unlock_q;
      own_d = own_q;
      if (wr_own)
      begin
         own_d.secure_module_port_select = crh_port_t'(req.wdata[CRH_OWN_PORT_LSB +: 2]); // RULE11
         if (unlock_q && !(req.wdata[CRH_OWN_HOST_BIT] && req.wdata[CRH_OWN_SECURE_BIT])) // RULE9 RULE10
         begin
            own_d.host_owns_link = req.wdata[CRH_OWN_HOST_BIT]; // RULE7
            own_d.secure_module_owns_link = req.wdata[CRH_OWN_SECURE_BIT]; // RULE8
         end
         // a locked write leaves owners as they were
         unlock_d = !unlock_q && req.wdata[CRH_OWN_UNLOCK_BIT]; // RULE5 RULE6 RULE16
      end
      else if (req.wr && unlock_q)
         unlock_d = 1'b0; // RULE6
   end

   // buffer control and threshold
   always_comb
   begin
      depth_d = depth_q;
      thr_d = thr_q;
      clear_d = wr_buf && req.wdata[CRH_BUF_CLEAR_BIT]; // RULE14
      if (wr_buf)
      begin
         depth_d = req.wdata[CRH_BUF_DEPTH_BIT]; // RULE12 RULE13
         thr_d[8] = req.wdata[CRH_BUF_THR_MSB_BIT]; // RULE12
      end
      if (wr_thr)
         thr_d[7:0] = req.wdata;
   end

   // read mux; reserved and write-only bits read zero
   always_comb
   begin
      rdata_d = rdata_q;
      if (req.rd)
      begin
         case (req.addr)
            CRH_OFS_COMMAND: rdata_d = cmd_q;
            // bit 4 and bits 1:0 are reserved and always read zero
            CRH_OFS_OWNER: rdata_d = {unlock_q, own_q.host_owns_link, own_q.secure_module_owns_link, 1'b0,
               own_q.secure_module_port_select, 2'h0}; // RULE16
            CRH_OFS_BUFFER: rdata_d = {depth_q, full_q, empty_q, 1'b0, 1'b0, thr_q[8], fill_count[9:8]}; // RULE12 RULE14
            CRH_OFS_THRESHOLD: rdata_d = thr_q[7:0];
            CRH_OFS_FILL: rdata_d = fill_count[7:0];
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // state registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cmd_q <= CRH_RST_COMMAND;
         unlock_q <= CRH_RST_OWNER[CRH_OWN_UNLOCK_BIT];
         own_q <= crh_owner_t'({CRH_RST_OWNER[6:5], CRH_RST_OWNER[3:2]});
         depth_q <= CRH_RST_BUFFER[CRH_BUF_DEPTH_BIT];
         thr_q <= 9'h000;
         clear_q <= 1'b0;
         rdata_q <= 8'h00;
         full_q <= 1'b0;
         empty_q <= 1'b0;
      end
      else
      begin
         cmd_q <= cmd_d;
         unlock_q <= unlock_d;
         own_q <= own_d;
         depth_q <= depth_d;
         thr_q <= thr_d;
         clear_q <= clear_d;
         rdata_q <= rdata_d;
         full_q <= full_c; // RULE15
         empty_q <= empty_c; // RULE15
      end
   end

   // outputs from flip-flops; radio_power_down ORs the two power bits
   assign rdata = rdata_q;
   assign power_down = cmd_q[CRH_CMD_STANDBY_BIT]; // RULE1
   assign radio_power_down = cmd_q[CRH_CMD_RADIO_OFF_BIT] | cmd_q[CRH_CMD_STANDBY_BIT]; // RULE2
   assign command_code = cmd_q[4:0]; // RULE3
   assign owner = own_q;
   assign owner_write_unlock = unlock_q;
   assign buffer_depth_select = depth_q;
   assign buffer_clear = clear_q; // RULE14
   assign threshold = thr_q;
   assign near_full_flag = full_q;
   assign near_empty_flag = empty_q;
endmodule : crh_regs

// >>> hw/crh_pkg.sv
// What this block does
// RULE1 - command bit 7 puts device in power-down
// RULE2 - command bit 6 powers down radio
// RULE3 - command bits 4:0 hold running command
// RULE4 - dynamic bits host-writable, cleared when command finishes
// RULE5 - unlock bit permits next owner register change
// RULE6 - first write after unlock clears unlock bit
// RULE7 - host-owner bit grants link to host
// RULE8 - secure-owner bit grants link to secure module
// RULE9 - both owner bits set is refused
// RULE10 - owner bits settable only after unlock
// RULE11 - port select: off, spi, light two-wire, i2c
// RULE12 - buffer control bit layout and access
// RULE13 - depth select: 1 gives 255, 0 gives 512
// RULE14 - buffer clear empties buffer, reads zero
// RULE15 - near-full and near-empty threshold compares
// RULE16 - locked write keeps owners; reserved bits zero
package crh_pkg;
   localparam logic [7:0] CRH_OFS_COMMAND = 8'h00;
   localparam logic [7:0] CRH_OFS_OWNER = 8'h01;
   localparam logic [7:0] CRH_OFS_BUFFER = 8'h02;
   localparam logic [7:0] CRH_OFS_THRESHOLD = 8'h03;
   localparam logic [7:0] CRH_OFS_FILL = 8'h04;
   localparam int CRH_CMD_STANDBY_BIT = 7;
   localparam int CRH_CMD_RADIO_OFF_BIT = 6;
   localparam int CRH_OWN_UNLOCK_BIT = 7;
   localparam int CRH_OWN_HOST_BIT = 6;
   localparam int CRH_OWN_SECURE_BIT = 5;
   localparam int CRH_OWN_PORT_LSB = 2;
   localparam int CRH_BUF_DEPTH_BIT = 7;
   localparam int CRH_BUF_FULL_BIT = 6;
   localparam int CRH_BUF_EMPTY_BIT = 5;
   localparam int CRH_BUF_CLEAR_BIT = 4;
   localparam int CRH_BUF_THR_MSB_BIT = 2;
   localparam logic [4:0] CRH_CMD_IDLE = 5'h00;
   localparam logic [9:0] CRH_DEPTH_SMALL = 10'h0ff;
   localparam logic [9:0] CRH_DEPTH_LARGE = 10'h200;
   localparam logic [7:0] CRH_RST_COMMAND = 8'h00;
   localparam logic [7:0] CRH_RST_OWNER = 8'h00;
   localparam logic [7:0] CRH_RST_BUFFER = 8'h00;

   typedef enum logic [1:0] {
      CRH_PORT_OFF = 2'h0,
      CRH_PORT_SPI = 2'h1,
      CRH_PORT_TWO_WIRE_LIGHT = 2'h2,
      CRH_PORT_I2C = 2'h3
   } crh_port_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } crh_req_t;

   typedef struct packed {
      logic host_owns_link;
      logic secure_module_owns_link;
      crh_port_t secure_module_port_select;
   } crh_owner_t;
endpackage : crh_pkg

// >>> hw/crh_level_cmp.sv
`timescale 1ns/100ps
// threshold compares for the buffer alerts
module crh_level_cmp
   import crh_pkg::*;
#(
   parameter int W = 10
)
(
   input wire logic [W-1:0] size,
   input wire logic [W-1:0] fill,
   input wire logic [W-1:0] thr,
   output logic near_full,
   output logic near_empty
);
   // a narrower compare could not hold the 512-byte size
   if (W < 10)
   begin : g_bad_width
      $error("crh_level_cmp: width too small for 512 bytes");
   end

   // fill never exceeds size, so the difference cannot wrap
   always_comb
   begin
      near_full = (size - fill) <= thr; // RULE15
      near_empty = fill <= thr; // RULE15
   end
endmodule : crh_level_cmp

// >>> verification/crh_regs_checker.sv
`timescale 1ns/100ps
// port checks of the register bank
module crh_regs_checker
   import crh_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire crh_req_t req,
   input wire logic cmd_done,
   input wire logic power_down,
   input wire logic radio_power_down,
   input wire logic [4:0] command_code,
   input wire crh_owner_t owner,
   input wire logic owner_write_unlock
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // decoded host writes
   wire w_cmd = req.wr && req.addr == 8'h00;
   wire w_own = req.wr && req.addr == 8'h01;
   // unlock and the owner write it admits are separate steps
   sequence s_unlock;
      w_own && req.wdata[7] && !owner_write_unlock;
   endsequence
   sequence s_apply;
      w_own && owner_write_unlock && !(req.wdata[6] && req.wdata[5]);
   endsequence
   property p_pd;
      w_cmd |=> power_down == $past(req.wdata[7]) && radio_power_down == ($past(req.wdata[6]) | power_down);
   endproperty
   a_pd: assert property (p_pd) else $error("power bits");
   property p_cmd;
      w_cmd |=> command_code == $past(req.wdata[4:0]);
   endproperty
   a_cmd: assert property (p_cmd) else $error("command code");
   property p_done;
      cmd_done && !w_cmd |=> command_code == 5'h00;
   endproperty
   a_done: assert property (p_done) else $error("done clear");
   property p_unl;
      s_unlock |=> owner_write_unlock;
   endproperty
   a_unl: assert property (p_unl) else $error("unlock");
   property p_use;
      owner_write_unlock && req.wr |=> !owner_write_unlock;
   endproperty
   a_use: assert property (p_use) else $error("unlock kept");
   property p_grant;
      s_apply |=> owner[3:2] == $past(req.wdata[6:5]);
   endproperty
   a_grant: assert property (p_grant) else $error("grant");
   property p_excl;
      !(owner.host_owns_link && owner.secure_module_owns_link);
   endproperty
   a_excl: assert property (p_excl) else $error("both owners");
   property p_lock;
      w_own && !owner_write_unlock |=> $stable(owner[3:2]) && owner[1:0] == $past(req.wdata[3:2]);
   endproperty
   a_lock: assert property (p_lock) else $error("locked write");
endmodule : crh_regs_checker
bind crh_regs crh_regs_checker chk_u (.*);

// >>> verification/crh_host.sv
`timescale 1ns/100ps
// host side: one access at a time
module crh_host
   import crh_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] rdata,
   output crh_req_t req
);
   initial req = '0;
   // hold to the taking edge; on release the strobes drop and address and data show inverted values
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      req <= '{w, !w, a, d};
      @(posedge clk);
      req <= '{1'b0, 1'b0, ~a, ~d};
      #1;
      q = rdata;
   endtask : xfer
endmodule : crh_host

// >>> verification/crh_regs_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module crh_regs_tb
   import crh_pkg::*;
;
   logic clk = 0, rst = 1, cmd_done = 0, power_down, radio_power_down, owner_write_unlock, buffer_clear;
   logic [9:0] fill_count = '0;
   logic [7:0] rdata, q;
   logic [4:0] command_code;
   logic buffer_depth_select, near_full_flag, near_empty_flag;
   logic [8:0] threshold;
   crh_req_t req;
   crh_owner_t owner;
   int failures = 0, n_checks = 0;
   // address, write data, read-back value
   logic [23:0] rows [10] = '{24'h00ffdf, 24'h004141, 24'h010000, 24'h010404, 24'h010808, 24'h010c0c,
      24'h05ff00, 24'h0290a0, 24'h020424, 24'h000000};
   always #5 clk = ~clk;
   crh_host host_u (.clk(clk), .rdata(rdata), .req(req));
   crh_regs dut_u (.*);
   // shorthand accesses
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host_u.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      host_u.xfer(1'b0, a, 8'h00, q);
   endtask : rd
   task automatic tally_and_finish;
      if (failures == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // main sequence
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i])
      begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16]);
         `CHK(q, rows[i][7:0])
      end
      // reset again in mid-run
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rd(8'h01);
      `CHK(q, 8'h00)
      // grant, refused double grant, locked write
      wr(8'h01, 8'h80);
      wr(8'h01, 8'h44);
      `CHK(owner.host_owns_link, 1'b1)
      wr(8'h01, 8'h80);
      wr(8'h01, 8'h60);
      wr(8'h01, 8'h20);
      rd(8'h01);
      `CHK(q, 8'h40)
      wr(8'h01, 8'h80);
      wr(8'h01, 8'h20);
      `CHK(owner.secure_module_owns_link, 1'b1)
      // finished command clears the code
      wr(8'h00, 8'h05);
      @(posedge clk);
      cmd_done <= 1'b1;
      @(posedge clk);
      cmd_done <= 1'b0;
      #1;
      `CHK(command_code, 5'h00)
      // flush pulse, then near-full boundary in the large mode
      wr(8'h02, 8'h14);
      `CHK(buffer_clear, 1'b1)
      @(posedge clk);
      fill_count <= 10'h101;
      rd(8'h02);
      `CHK(q, 8'h45)
      `CHK(near_full_flag, 1'b1)
      `CHK(near_empty_flag, 1'b0)
      `CHK(threshold, 9'h100)
      `CHK(buffer_depth_select, 1'b0)
      `CHK(power_down, 1'b0)
      `CHK(radio_power_down, 1'b0)
      tally_and_finish();
   end
   // hang guard
   initial
   begin
      #100000;
      failures++;
      tally_and_finish();
   end
endmodule : crh_regs_tb
